// file: design/lac_addr_counter.v
// display-ram x/y address counters and common-line select
`timescale 1ns/1ps
`include "lac_consts.vh"

module lac_addr_counter (
    // clock and reset
    input wire ref_clk,
    input wire resetn,
    // configuration
    input wire variant_18com,
    input wire duty_select_high,
    input wire duty_select_low,
    input wire word_length_select,
    input wire inc_x_dir,
    // host load and access
    input wire load_x,
    input wire load_y,
    input wire [3:0] load_data_x,
    input wire [4:0] load_data_y,
    input wire data_access,
    // scan
    input wire line_advance,
    // outputs
    output reg [3:0] x_addr_q,
    output reg [4:0] y_addr_q,
    output reg [17:0] com_select_q,
    output reg [4:0] y_max_q
);
    // ==========================================
    // duty codes
    localparam [1:0] DUTY_LOW = 2'h0;
    localparam [1:0] DUTY_MID = 2'h1;

    // ==========================================
    // internal signals
    wire [1:0] duty_code;
    wire duty_is_low;
    wire duty_is_mid;
    reg [4:0] y_max;
    reg [3:0] x_max;
    wire x_wrap;
    wire y_wrap;
    wire [3:0] x_inc;
    wire [4:0] y_inc;
    wire access_go;
    reg [3:0] x_step;
    reg [4:0] y_step;
    reg [3:0] x_d;
    reg [4:0] y_d;
    reg [4:0] scan_q;
    reg [4:0] scan_d;
    wire [17:0] line_hit;
    reg common_out_nine_off;
    reg common_out_ten_off;
    reg common_out_seventeen_off;
    reg common_out_eighteen_off;
    reg [17:0] unused_mask;
    wire [17:0] com_select_d;

    // ==========================================
    // y range from variant and duty
    assign duty_code = {duty_select_high, duty_select_low};
    assign duty_is_low = (duty_code == DUTY_LOW);
    assign duty_is_mid = (duty_code == DUTY_MID);

    always @* begin
        case (duty_code)
            DUTY_LOW: begin
                if (variant_18com)
                    y_max = `LAC_Y_MAX_D16;
                else
                    y_max = `LAC_Y_MAX_D8;
            end
            DUTY_MID: begin
                if (variant_18com)
                    y_max = `LAC_Y_MAX_D17;
                else
                    y_max = `LAC_Y_MAX_D9;
            end
            // codes 2 and 3 both pick the highest duty
            default: begin
                if (variant_18com)
                    y_max = `LAC_Y_MAX_D18;
                else
                    y_max = `LAC_Y_MAX_D10;
            end
        endcase
    end

    // ==========================================
    // x range from word length
    always @* begin
        if (word_length_select)
            x_max = `LAC_X_MAX_W6;
        else
            x_max = `LAC_X_MAX_W8;
    end

    // ==========================================
    // wrap detection and increments
    // out-of-range loads just wrap at their counter's next step
    assign x_wrap = (x_addr_q >= x_max);
    assign y_wrap = (y_addr_q >= y_max);
    assign x_inc = x_addr_q + 4'h1;
    assign y_inc = y_addr_q + 5'h01;
    // a load in the same cycle beats the access
    assign access_go = data_access && !load_x && !load_y;

    // ==========================================
    // auto increment step
    always @* begin
        x_step = x_addr_q;
        y_step = y_addr_q;
        if (inc_x_dir) begin
            if (x_wrap) begin
                x_step = 4'h0;
                if (y_wrap)
                    y_step = 5'h00;
                else
                    y_step = y_inc;
            end else begin
                x_step = x_inc;
            end
        end else begin
            if (y_wrap) begin
                y_step = 5'h00;
                if (x_wrap)
                    x_step = 4'h0;
                else
                    x_step = x_inc;
            end else begin
                y_step = y_inc;
            end
        end
    end

    // ==========================================
    // counter next state
    always @* begin
        x_d = x_addr_q;
        y_d = y_addr_q;
        if (load_x)
            x_d = load_data_x;
        if (load_y)
            y_d = load_data_y;
        if (access_go) begin
            x_d = x_step;
            y_d = y_step;
        end
    end

    // ==========================================
    // common line scan
    always @* begin
        scan_d = scan_q;
        if (line_advance) begin
            if (scan_q >= y_max)
                scan_d = `LAC_RST_SCAN;
            else
                scan_d = scan_q + 5'h01;
        end
    end

    // one compare per common line
    genvar i;
    generate
        for (i = 0; i < `LAC_NCOM; i = i + 1) begin : g_line
            assign line_hit[i] = ({27'h0000000, scan_d} == i);
        end
    endgenerate

    // ==========================================
    // non-select commons by duty
    always @* begin
        common_out_nine_off = 1'h0;
        common_out_ten_off = 1'h0;
        common_out_seventeen_off = 1'h0;
        common_out_eighteen_off = 1'h0;
        if (variant_18com) begin
            if (duty_is_low) begin
                common_out_seventeen_off = 1'h1;
                common_out_eighteen_off = 1'h1;
            end else if (duty_is_mid) begin
                common_out_eighteen_off = 1'h1;
            end
        end else begin
            if (duty_is_low) begin
                common_out_nine_off = 1'h1;
                common_out_ten_off = 1'h1;
            end else if (duty_is_mid) begin
                common_out_ten_off = 1'h1;
            end
        end
    end

    // lines 11 to 18 do not exist on the ten-common variant
    always @* begin
        unused_mask = `LAC_RST_COM;
        unused_mask[8] = common_out_nine_off;
        unused_mask[9] = common_out_ten_off;
        if (variant_18com) begin
            unused_mask[16] = common_out_seventeen_off;
            unused_mask[17] = common_out_eighteen_off;
        end else begin
            unused_mask[17:10] = 8'hFF;
        end
    end

    // masked lines carry only the non-select waveform
    assign com_select_d = line_hit & ~unused_mask;

    // ==========================================
    // registers
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            x_addr_q <= `LAC_RST_X;
            y_addr_q <= `LAC_RST_Y;
            scan_q <= `LAC_RST_SCAN;
            com_select_q <= `LAC_RST_COM;
            y_max_q <= `LAC_RST_YMAX;
        end else begin
            x_addr_q <= x_d;
            y_addr_q <= y_d;
            scan_q <= scan_d;
            com_select_q <= com_select_d;
            y_max_q <= y_max;
        end
    end
endmodule // lac_addr_counter

// file: design/lac_consts.vh
// constants for the display-ram address counter block
`ifndef LAC_CONSTS_VH
`define LAC_CONSTS_VH
`define LAC_X_MAX_W8 4'h9
`define LAC_X_MAX_W6 4'hD
`define LAC_Y_MAX_D8 5'h07
`define LAC_Y_MAX_D9 5'h08
`define LAC_Y_MAX_D10 5'h09
`define LAC_Y_MAX_D16 5'h0F
`define LAC_Y_MAX_D17 5'h10
`define LAC_Y_MAX_D18 5'h11
`define LAC_NCOM 18
`define LAC_RST_X 4'h0
`define LAC_RST_Y 5'h00
`define LAC_RST_COM 18'h00000
`define LAC_RST_SCAN 5'h00
`define LAC_RST_YMAX 5'h00
`endif

// file: verification/lac_addr_counter_checker.sv
// port assertions for the address counter block
`timescale 1ns/1ps
`include "lac_consts.vh"
module lac_addr_counter_checker(input wire ref_clk, resetn, variant_18com,
    duty_select_high, duty_select_low, word_length_select, inc_x_dir, load_x,
    load_y, data_access, line_advance, input wire [3:0] load_data_x, x_addr_q,
    input wire [4:0] load_data_y, y_addr_q, y_max_q,
    input wire [17:0] com_select_q);
wire ac = data_access && !load_x && !load_y;
wire [3:0] xm = word_length_select ? `LAC_X_MAX_W6 : `LAC_X_MAX_W8;
wire [4:0] ym = (variant_18com ? 5'h0F : 5'h07)
    + (duty_select_high ? 5'h02 : {4'h0, duty_select_low});
default clocking @(posedge ref_clk); endclocking
default disable iff (!resetn);
a_y_max:
assert property ($past(resetn) |-> y_max_q == $past(ym)) else $error("ymax");
a_com_unused:
assert property ((com_select_q >> y_max_q) <= 18'h1) else $error("com");
a_y_step:
assert property (ac && !inc_x_dir && y_addr_q < y_max_q |=> y_addr_q ==
    $past(y_addr_q) + 5'h1 && $stable(x_addr_q)) else $error("y step");
a_y_wrap:
assert property (ac && !inc_x_dir && y_addr_q == y_max_q && x_addr_q < xm
    |=> y_addr_q == 5'h0 && x_addr_q == $past(x_addr_q) + 4'h1)
    else $error("y wrap");
a_x_step:
assert property (ac && inc_x_dir && x_addr_q < xm |=> x_addr_q ==
    $past(x_addr_q) + 4'h1 && $stable(y_addr_q)) else $error("x step");
a_x_wrap:
assert property (ac && inc_x_dir && x_addr_q == xm && y_addr_q < y_max_q
    |=> x_addr_q == 4'h0 && y_addr_q == $past(y_addr_q) + 5'h1)
    else $error("x wrap");
a_hold_idle:
assert property ($past(resetn) && !data_access && !load_x && !load_y |=>
    $stable(x_addr_q) && $stable(y_addr_q)) else $error("hold");
a_load_x:
assert property (load_x |=> x_addr_q == $past(load_data_x)) else $error("ld");
a_load_y:
assert property (load_y |=> y_addr_q == $past(load_data_y))
    else $error("ld y");
a_load_wins:
assert property (load_x && !load_y |=> $stable(y_addr_q))
    else $error("load wins");
endmodule // lac_addr_counter_checker
bind lac_addr_counter lac_addr_counter_checker i_chk(.*);

// file: verification/lac_host_model.sv
// host-side model issuing display data accesses
`timescale 1ns/1ps
module lac_host_model(input wire ref_clk, input wire host_en,
    output reg data_access);
initial data_access = 1'b0;
// one completed access per cycle while enabled
always @(negedge ref_clk) data_access <= host_en;
endmodule // lac_host_model

// file: verification/test_lac_addr_counter.sv
// bench for the display-ram address counter block
`timescale 1ns/1ps
module test_lac_addr_counter;
reg ref_clk=0, resetn=0, variant_18com=0, duty_select_high=0;
reg duty_select_low=0, word_length_select=0, inc_x_dir=0, load_x=0;
reg load_y=0, line_advance=1, host_en=0;
reg [3:0] load_data_x=4'h0;
reg [4:0] load_data_y=5'h00;
wire data_access;
wire [3:0] x_addr_q;
wire [4:0] y_addr_q, y_max_q;
wire [17:0] com_select_q;
integer failures=0, check_count=0, cyc=0, i;
lac_host_model i_host(.ref_clk(ref_clk), .host_en(host_en),
    .data_access(data_access));
lac_addr_counter i_dut(.ref_clk(ref_clk), .resetn(resetn),
    .variant_18com(variant_18com), .duty_select_high(duty_select_high),
    .duty_select_low(duty_select_low),
    .word_length_select(word_length_select), .inc_x_dir(inc_x_dir),
    .load_x(load_x), .load_y(load_y), .load_data_x(load_data_x),
    .load_data_y(load_data_y), .data_access(data_access),
    .line_advance(line_advance), .x_addr_q(x_addr_q), .y_addr_q(y_addr_q),
    .com_select_q(com_select_q), .y_max_q(y_max_q));
initial forever #2 ref_clk = ~ref_clk;
task cmp(input [4:0] g, input [4:0] e); begin
    check_count = check_count + 1;
    if (g !== e) begin
        failures = failures + 1;
        $display("Error %0t: got %0d exp %0d", $time, g, e);
    end
end endtask
task cmp_com(input [17:0] g, input [17:0] e); begin
    check_count = check_count + 1;
    if (g !== e) begin
        failures = failures + 1;
        $display("Error %0t: com got %0h exp %0h", $time, g, e);
    end
end endtask
task ld; begin
    @(negedge ref_clk) {load_x, load_y, load_data_x, load_data_y} <= 11'h600;
    @(negedge ref_clk) {load_x, load_y} <= 2'h0;
end endtask
task acc(input integer n); begin
    @(negedge ref_clk) host_en <= 1'b1;
    repeat (n) @(negedge ref_clk);
    host_en <= 1'b0;
    repeat (2) @(negedge ref_clk);
end endtask
task t_ywrap(input [2:0] c); integer m; reg [17:0] seen, exp_com; begin
    m = (c[2] ? 15 : 7) + (c[1] ? 2 : c[0]);
    @(negedge ref_clk) {variant_18com, duty_select_high, duty_select_low} <= c;
    inc_x_dir <= 1'b0;
    ld;
    seen = 18'h00000;
    exp_com = (18'h00001 << (m + 1)) - 18'h00001;
    repeat (m + 1) @(negedge ref_clk) seen = seen | com_select_q;
    cmp_com(seen, exp_com);
    acc(m);
    cmp(y_addr_q, m[4:0]);
    cmp(y_max_q, m[4:0]);
    acc(1);
    cmp(y_addr_q, 5'h00);
    cmp({1'b0, x_addr_q}, 5'h01);
end endtask
task t_xwrap(input w); integer m; begin
    m = w ? 13 : 9;
    @(negedge ref_clk) {word_length_select, inc_x_dir} <= {w, 1'b1};
    ld;
    acc(m);
    cmp({1'b0, x_addr_q}, m[4:0]);
    acc(1);
    cmp({1'b0, x_addr_q}, 5'h00);
    cmp(y_addr_q, 5'h01);
end endtask
task t_ldwin; begin
    @(negedge ref_clk) host_en <= 1'b1;
    @(negedge ref_clk) {load_x, load_data_x} <= 5'h15;
    @(negedge ref_clk) {load_x, host_en} <= 2'h0;
    repeat (2) @(negedge ref_clk);
    cmp({1'b0, x_addr_q}, 5'h06);
    cmp(y_addr_q, 5'h01);
end endtask
task t_reset; begin
    @(negedge ref_clk) resetn <= 1'b0;
    repeat (2) @(negedge ref_clk);
    resetn <= 1'b1;
    repeat (2) @(negedge ref_clk);
    cmp(y_max_q, 5'h11);
    acc(1);
    cmp({1'b0, x_addr_q}, 5'h01);
    cmp(y_addr_q, 5'h00);
end endtask
task summarize; begin
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
end endtask
always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
        failures = failures + 1;
        summarize;
    end
end
initial begin
    repeat (5) @(negedge ref_clk);
    resetn <= 1'b1;
    for (i = 0; i < 8; i = i + 1) t_ywrap(i[2:0]);
    t_xwrap(1'b0);
    t_xwrap(1'b1);
    t_ldwin;
    t_reset;
    summarize;
end
endmodule // test_lac_addr_counter
